// file: logic/clkgen_cfg_pkg.sv
// constants for the clock generator serial configuration bank
package clkgen_cfg_pkg;
    // ------------------------------------------------------------
    // serial addressing
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_WRITE = 8'hd2; // address byte, write
    localparam logic [7:0] ADDR_READ = 8'hd3;  // address byte, read
    localparam int CMD_BYTE_OP_BIT = 7;        // command: byte access flag
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_BIT = 4'h7;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int NUM_REGS = 5;
    localparam logic [6:0] SPREAD_AND_FREQ_SELECT = 7'h00;
    localparam logic [6:0] PROC_AND_66M_OUTPUT_ENABLES = 7'h01;
    localparam logic [6:0] PCI_OUTPUT_ENABLES = 7'h02;
    localparam logic [6:0] FREERUN_PCI_REF_ENABLES = 7'h03;
    localparam logic [6:0] CURRENT_MULTIPLIER_CONTROL = 7'h04;

    // power-up values, reserved bits included
    localparam logic [7:0] RST_BYTE0 = 8'h00;
    localparam logic [7:0] RST_BYTE1 = 8'hff;
    localparam logic [7:0] RST_BYTE2 = 8'h7f;
    localparam logic [7:0] RST_BYTE3 = 8'heb;
    localparam logic [7:0] RST_BYTE4 = 8'h00;

    // writable bits per byte; the rest keep the power-up value
    localparam logic [7:0] WMASK_BYTE0 = 8'hff;
    localparam logic [7:0] WMASK_BYTE1 = 8'hff;
    localparam logic [7:0] WMASK_BYTE2 = 8'h7f;
    localparam logic [7:0] WMASK_BYTE3 = 8'heb;
    localparam logic [7:0] WMASK_BYTE4 = 8'he0;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SPREAD_MSB = 7;
    localparam int SPREAD_LSB = 5;
    localparam int FREQ_MSB = 4;
    localparam int FREQ_LSB = 0;
    localparam int MULT_OVR_BIT = 7;
    localparam int SW_MULT_MSB = 6;
    localparam int SW_MULT_LSB = 5;

    // spread codes
    localparam logic [2:0] SPREAD_OFF = 3'h0;
    localparam logic [2:0] SPREAD_CTR_025 = 3'h4;
    localparam logic [2:0] SPREAD_DOWN_05 = 3'h5;
    localparam logic [2:0] SPREAD_CTR_05 = 3'h6;
    localparam logic [2:0] SPREAD_CTR_038 = 3'h7;

    // cycles after reset release before the straps are caught
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
endpackage

// file: logic/pin_sync.sv
// two-flop synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta; // first stage, read only by q

    // ------------------------------------------------------------
    // two stages, nothing else looks at the first
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            // ones: bus pins idle high, so no false edge at release
            meta <= '1;
            q <= '1;
        end else begin
            meta <= d;
            q <= meta;
        end
    end
endmodule

// file: logic/smbus_cfg_regs.sv
// serial-bus slave with the clock generator configuration bytes 0..4
`timescale 1ns/1ps
// Notes on behaviour
// [RULE1] host starts, sends address and write bit
// [RULE2] command msb one selects byte access, acked
// [RULE3] byte write updates indexed register, acked
// [RULE4] byte read: repeated start, device sends byte
// [RULE5] byte 0 bits 7..5 select spread mode
// [RULE6] byte 0 bits 4..0 software frequency code
// [RULE7] byte 1 per-output enables, default all one
// [RULE8] bytes 2 and 3 enables, reserved bits fixed
// [RULE9] byte 4 bit 7 picks strap or software
// [RULE10] byte 4 bits 6..5 software current multiplier
// [RULE11] answer only address byte d2, read d3
// [RULE12] msb first; registers start at defaults
// [RULE13] reserved bits ignore writes, read default
module smbus_cfg_regs (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    output logic SDA_OUT,
    output logic SDA_OE,
    input wire logic [1:0] CURRENT_MULT_STRAP_PINS,
    output logic [2:0] SPREAD_CODE,
    output logic [4:0] SW_FREQ_CODE,
    output logic [7:0] PROC_HUB_USB_EN,
    output logic [6:0] PERIPH_CLK_EN,
    output logic [7:0] FREERUN_REF_EN,
    output logic CURRENT_MULT_SW_OVERRIDE,
    output logic [1:0] CURRENT_MULT_SEL
);
    // ------------------------------------------------------------
    // types and storage
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        IDLE, ADDR, ADDR_ACK, CMD, CMD_ACK,
        WDATA, WDATA_ACK, RDATA, RDATA_ACK, IGNORE
    } state_t;

    state_t st;                           // transfer state
    logic [3:0] bit_cnt;                  // bits of current byte
    logic [7:0] shreg;                    // shift register, msb first
    logic [6:0] index;                    // register index from command
    logic rd_dir;                         // address carried the read bit
    logic [7:0] rd_byte;                  // indexed byte for a read
    logic [7:0] cfg [clkgen_cfg_pkg::NUM_REGS]; // configuration bytes
    logic scl_s, sda_s;                   // synchronised pins
    logic [1:0] strap_s;                  // synchronised straps
    logic scl_d, sda_d;                   // one cycle older copies
    logic scl_rise, scl_fall, start_c, stop_c;
    logic wr_en;                          // write strobe for cfg
    logic [1:0] strap_latched;            // straps caught after reset
    logic [1:0] settle_cnt;               // wait for synchroniser fill
    logic strap_done;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // power-up value of a byte, 0 for unmapped indices
    function automatic logic [7:0] reset_val(input logic [6:0] i);
        unique case (i)
            clkgen_cfg_pkg::SPREAD_AND_FREQ_SELECT:
                return clkgen_cfg_pkg::RST_BYTE0;
            clkgen_cfg_pkg::PROC_AND_66M_OUTPUT_ENABLES:
                return clkgen_cfg_pkg::RST_BYTE1;
            clkgen_cfg_pkg::PCI_OUTPUT_ENABLES:
                return clkgen_cfg_pkg::RST_BYTE2;
            clkgen_cfg_pkg::FREERUN_PCI_REF_ENABLES:
                return clkgen_cfg_pkg::RST_BYTE3;
            clkgen_cfg_pkg::CURRENT_MULTIPLIER_CONTROL:
                return clkgen_cfg_pkg::RST_BYTE4;
            default: return 8'h00;
        endcase
    endfunction

    // writable bits of a byte, none for unmapped indices
    function automatic logic [7:0] wmask(input logic [6:0] i);
        unique case (i)
            clkgen_cfg_pkg::SPREAD_AND_FREQ_SELECT:
                return clkgen_cfg_pkg::WMASK_BYTE0;
            clkgen_cfg_pkg::PROC_AND_66M_OUTPUT_ENABLES:
                return clkgen_cfg_pkg::WMASK_BYTE1;
            clkgen_cfg_pkg::PCI_OUTPUT_ENABLES:
                return clkgen_cfg_pkg::WMASK_BYTE2;
            clkgen_cfg_pkg::FREERUN_PCI_REF_ENABLES:
                return clkgen_cfg_pkg::WMASK_BYTE3;
            clkgen_cfg_pkg::CURRENT_MULTIPLIER_CONTROL:
                return clkgen_cfg_pkg::WMASK_BYTE4;
            default: return 8'h00;
        endcase
    endfunction

    // indexed byte for a read; unmapped indices read zero
    assign rd_byte = (index < 7'(clkgen_cfg_pkg::NUM_REGS))
        ? cfg[index[2:0]] : 8'h00;

    // ------------------------------------------------------------
    // pin synchronisation and edge detection
    // ------------------------------------------------------------
    pin_sync #(.W(4)) pin_sync_inst (
        .CLK(CLK),
        .RST(RST),
        .d({SCL_IN, SDA_IN, CURRENT_MULT_STRAP_PINS}),
        .q({scl_s, sda_s, strap_s})
    );

    // delayed copies; idle bus is high
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    assign scl_rise = scl_s & ~scl_d;
    assign scl_fall = ~scl_s & scl_d;
    assign start_c = scl_s & scl_d & sda_d & ~sda_s; // RULE1
    assign stop_c = scl_s & scl_d & ~sda_d & sda_s;

    // open drain: only ever pulls low
    assign SDA_OUT = 1'b0;

    // ------------------------------------------------------------
    // transfer state machine
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            st <= IDLE;
            bit_cnt <= 4'h0;
            shreg <= 8'h00;
            index <= 7'h00;
            rd_dir <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (start_c) begin
            // start or repeated start, always re-arms
            st <= ADDR; // RULE4
            bit_cnt <= 4'h0;
            SDA_OE <= 1'b0;
        end else if (stop_c) begin
            st <= IDLE;
            SDA_OE <= 1'b0;
        end else if (scl_rise) begin
            // sample incoming bits, msb first
            if ((st == ADDR || st == CMD || st == WDATA)
                    && bit_cnt != clkgen_cfg_pkg::BITS_PER_BYTE) begin
                shreg <= {shreg[6:0], sda_s}; // RULE12
                bit_cnt <= bit_cnt + 4'h1;
            end else if (st == RDATA_ACK) begin
                // master answers; only single byte is served
                st <= IGNORE; // RULE4
            end
        end else if (scl_fall) begin
            unique case (st)
                ADDR: begin
                    if (bit_cnt == clkgen_cfg_pkg::BITS_PER_BYTE) begin
                        if (shreg == clkgen_cfg_pkg::ADDR_WRITE) begin
                            rd_dir <= 1'b0; // RULE11
                            st <= ADDR_ACK;
                            SDA_OE <= 1'b1; // RULE1
                        end else if (shreg == clkgen_cfg_pkg::ADDR_READ) begin
                            rd_dir <= 1'b1; // RULE11
                            st <= ADDR_ACK;
                            SDA_OE <= 1'b1; // RULE4
                        end else begin
                            st <= IGNORE; // RULE11
                        end
                    end
                end
                ADDR_ACK: begin
                    bit_cnt <= 4'h0;
                    if (rd_dir) begin
                        // first data bit goes out right away
                        st <= RDATA;
                        shreg <= rd_byte;
                        SDA_OE <= ~rd_byte[7]; // RULE4
                    end else begin
                        st <= CMD;
                        SDA_OE <= 1'b0;
                    end
                end
                CMD: begin
                    if (bit_cnt == clkgen_cfg_pkg::BITS_PER_BYTE) begin
                        // block access is not served: no ack
                        if (shreg[clkgen_cfg_pkg::CMD_BYTE_OP_BIT]) begin
                            index <= shreg[6:0]; // RULE2
                            st <= CMD_ACK;
                            SDA_OE <= 1'b1; // RULE2
                        end else begin
                            st <= IGNORE;
                        end
                    end
                end
                CMD_ACK: begin
                    st <= WDATA;
                    bit_cnt <= 4'h0;
                    SDA_OE <= 1'b0;
                end
                WDATA: begin
                    if (bit_cnt == clkgen_cfg_pkg::BITS_PER_BYTE) begin
                        st <= WDATA_ACK;
                        SDA_OE <= 1'b1; // RULE3
                    end
                end
                WDATA_ACK: begin
                    // further bytes are not acked; host sends stop
                    st <= IGNORE; // RULE3
                    SDA_OE <= 1'b0;
                end
                RDATA: begin
                    if (bit_cnt == clkgen_cfg_pkg::LAST_BIT) begin
                        st <= RDATA_ACK;
                        SDA_OE <= 1'b0;
                    end else begin
                        shreg <= {shreg[6:0], 1'b0};
                        SDA_OE <= ~shreg[6]; // RULE12
                        bit_cnt <= bit_cnt + 4'h1;
                    end
                end
                IDLE, RDATA_ACK, IGNORE: begin
                    SDA_OE <= 1'b0;
                end
            endcase
        end
    end

    // write strobe on the falling edge after the eighth data bit
    assign wr_en = scl_fall & ~start_c & ~stop_c & (st == WDATA)
        & (bit_cnt == clkgen_cfg_pkg::BITS_PER_BYTE);

    // ------------------------------------------------------------
    // configuration bytes
    // ------------------------------------------------------------
    for (genvar g = 0; g < clkgen_cfg_pkg::NUM_REGS; g++) begin : g_cfg
        // each byte keeps reserved bits at their default
        always_ff @(posedge CLK or posedge RST) begin
            if (RST) begin
                cfg[g] <= reset_val(7'(g)); // RULE12
            end else if (wr_en && index == 7'(g)) begin
                cfg[g] <= (shreg & wmask(7'(g)))
                    | (reset_val(7'(g)) & ~wmask(7'(g))); // RULE3 RULE13
            end
        end
    end

    // ------------------------------------------------------------
    // strap capture after reset release
    // ------------------------------------------------------------
    // wait until synchroniser holds real pin values, then latch once
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            settle_cnt <= 2'h0;
            strap_done <= 1'b0;
            strap_latched <= 2'h0;
        end else if (!strap_done) begin
            if (settle_cnt == clkgen_cfg_pkg::STRAP_SETTLE) begin
                strap_latched <= strap_s;
                strap_done <= 1'b1;
            end else begin
                settle_cnt <= settle_cnt + 2'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // registered field outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            SPREAD_CODE <= clkgen_cfg_pkg::SPREAD_OFF;
            SW_FREQ_CODE <= 5'h00;
            PROC_HUB_USB_EN <= clkgen_cfg_pkg::RST_BYTE1;
            PERIPH_CLK_EN <= clkgen_cfg_pkg::RST_BYTE2[6:0];
            FREERUN_REF_EN <= clkgen_cfg_pkg::RST_BYTE3;
            CURRENT_MULT_SW_OVERRIDE <= 1'b0;
            CURRENT_MULT_SEL <= 2'h0;
        end else begin
            SPREAD_CODE <= cfg[0][clkgen_cfg_pkg::SPREAD_MSB:
                clkgen_cfg_pkg::SPREAD_LSB]; // RULE5
            SW_FREQ_CODE <= cfg[0][clkgen_cfg_pkg::FREQ_MSB:
                clkgen_cfg_pkg::FREQ_LSB]; // RULE6
            PROC_HUB_USB_EN <= cfg[1]; // RULE7
            PERIPH_CLK_EN <= cfg[2][6:0]; // RULE8
            FREERUN_REF_EN <= cfg[3]; // RULE8
            CURRENT_MULT_SW_OVERRIDE <=
                cfg[4][clkgen_cfg_pkg::MULT_OVR_BIT];
            // software field wins only with the override set
            if (cfg[4][clkgen_cfg_pkg::MULT_OVR_BIT]) begin
                CURRENT_MULT_SEL <= cfg[4][clkgen_cfg_pkg::SW_MULT_MSB:
                    clkgen_cfg_pkg::SW_MULT_LSB]; // RULE9 RULE10
            end else begin
                CURRENT_MULT_SEL <= strap_latched; // RULE9
            end
        end
    end
endmodule

// file: verification/smbus_cfg_regs_chk.sv
// concurrent checks on the configuration bank ports
`timescale 1ns/1ps
module smbus_cfg_regs_chk (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SCL_IN,
    input wire logic SDA_IN,
    input wire logic SDA_OUT,
    input wire logic SDA_OE,
    input wire logic [1:0] CURRENT_MULT_STRAP_PINS,
    input wire logic [2:0] SPREAD_CODE,
    input wire logic [4:0] SW_FREQ_CODE,
    input wire logic [7:0] PROC_HUB_USB_EN,
    input wire logic [6:0] PERIPH_CLK_EN,
    input wire logic [7:0] FREERUN_REF_EN,
    input wire logic CURRENT_MULT_SW_OVERRIDE,
    input wire logic [1:0] CURRENT_MULT_SEL
);
    // ------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------
    logic [4:0] age; // cycles since reset release, saturating
    // strap capture is allowed to move the multiplier early on
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            age <= 5'h0;
        end else if (age != 5'h1f) begin
            age <= age + 5'h1;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_reset_defaults: assert property ($fell(RST) |-> !SDA_OE &&
        SPREAD_CODE == 3'h0 && SW_FREQ_CODE == 5'h0 &&
        PROC_HUB_USB_EN == 8'hff && PERIPH_CLK_EN == 7'h7f &&
        FREERUN_REF_EN == 8'heb && !CURRENT_MULT_SW_OVERRIDE &&
        CURRENT_MULT_SEL == 2'h0) else $error("outputs not at defaults");
    a_sda_value_low: assert property (SDA_OUT == 1'b0)
        else $error("data pin value not low");
    a_reserved_zero: assert property (FREERUN_REF_EN[4] == 1'b0 &&
        FREERUN_REF_EN[2] == 1'b0) else $error("reserved enable set");
    a_oe_clock_low: assert property ($changed(SDA_OE) |->
        !$past(SCL_IN, 2)) else $error("data moved with clock high");
    a_ack_holds_slot: assert property ($rose(SDA_OE) |->
        SDA_OE[*6]) else $error("data drive too short");
    a_oe_bounded: assert property ($rose(SDA_OE) |->
        ##[1:100] !SDA_OE) else $error("data drive never released");
    a_byte0_on_ack: assert property (
        !$stable({SPREAD_CODE, SW_FREQ_CODE}) |-> SDA_OE)
        else $error("byte 0 moved outside an ack");
    a_enables_on_ack: assert property (!$stable({PROC_HUB_USB_EN,
        PERIPH_CLK_EN, FREERUN_REF_EN}) |-> SDA_OE)
        else $error("enables moved outside an ack");
    a_mult_on_ack: assert property (age > 5'h10 &&
        !$stable({CURRENT_MULT_SW_OVERRIDE, CURRENT_MULT_SEL}) |-> SDA_OE)
        else $error("multiplier moved outside an ack");
    // main scenarios seen
    cover property ($rose(SDA_OE));
    cover property ($changed(SPREAD_CODE));
    cover property (CURRENT_MULT_SW_OVERRIDE && CURRENT_MULT_SEL == 2'h3);
endmodule
bind smbus_cfg_regs smbus_cfg_regs_chk smbus_cfg_regs_chk_inst (
    .CLK(CLK), .RST(RST), .SCL_IN(SCL_IN), .SDA_IN(SDA_IN),
    .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .CURRENT_MULT_STRAP_PINS(CURRENT_MULT_STRAP_PINS),
    .SPREAD_CODE(SPREAD_CODE), .SW_FREQ_CODE(SW_FREQ_CODE),
    .PROC_HUB_USB_EN(PROC_HUB_USB_EN), .PERIPH_CLK_EN(PERIPH_CLK_EN),
    .FREERUN_REF_EN(FREERUN_REF_EN),
    .CURRENT_MULT_SW_OVERRIDE(CURRENT_MULT_SW_OVERRIDE),
    .CURRENT_MULT_SEL(CURRENT_MULT_SEL));

// file: verification/smbus_host.sv
// serial-bus host model: owns the bus clock, drives data open-drain
`timescale 1ns/1ps
module smbus_host (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sda_drv
);
    // idle: clock stands high, data released to the pull-up
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // all moves on falling system edges; halves of 4 cycles = 16 ns
    task automatic wt(input int n);
        repeat (n) @(negedge clk);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        sda_drv = 1'b1;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_drv = 1'b0;
        wt(4);
        scl = 1'b0;
        wt(2);
    endtask
    // stop: data rises while clock high, then clock stands still
    task automatic stop();
        sda_drv = 1'b0;
        wt(2);
        scl = 1'b1;
        wt(4);
        sda_drv = 1'b1;
        wt(4);
    endtask
    // one bit slot; data set mid-low, line sampled mid-high
    task automatic bit_io(input logic b, output logic s);
        sda_drv = b;
        wt(2);
        scl = 1'b1;
        wt(2);
        s = sda;
        wt(2);
        scl = 1'b0;
        wt(2);
    endtask
    // eight bits msb first, then a released ninth slot (ack or nack)
    task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
                           output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bit_io(tx[i], rx[i]);
        end
        bit_io(1'b1, ack);
    endtask
endmodule

// file: verification/smbus_cfg_regs_tb.sv
// self-checking bench for the serial configuration bank
`timescale 1ns/1ps
module smbus_cfg_regs_tb;
    logic clk; // system clock
    logic rst; // reset, high active
    logic [1:0] strap; // strap pin levels
    logic scl; // bus clock from host
    logic sda_drv; // host data, 1 = released
    logic sda_out; // device data value
    logic sda_oe; // device pulls data
    logic sda; // wired data line with pull-up
    logic [2:0] spread;
    logic [4:0] freq;
    logic [7:0] en1;
    logic [6:0] en2;
    logic [7:0] en3;
    logic ovr;
    logic [1:0] mult;
    int bad_count;
    int checks_done;
    logic [7:0] d;
    logic [7:0] e;
    logic [2:0] ak;
    logic [7:0] rstv [5] = '{clkgen_cfg_pkg::RST_BYTE0,
        clkgen_cfg_pkg::RST_BYTE1, clkgen_cfg_pkg::RST_BYTE2,
        clkgen_cfg_pkg::RST_BYTE3, clkgen_cfg_pkg::RST_BYTE4};
    logic [7:0] wmask [5] = '{clkgen_cfg_pkg::WMASK_BYTE0,
        clkgen_cfg_pkg::WMASK_BYTE1, clkgen_cfg_pkg::WMASK_BYTE2,
        clkgen_cfg_pkg::WMASK_BYTE3, clkgen_cfg_pkg::WMASK_BYTE4};
    logic [7:0] pats [3] = '{8'hff, 8'h00, 8'ha5};
    logic [2:0] codes [5] = '{3'h0, 3'h4, 3'h5, 3'h6, 3'h7};
    // wired-and of both parties on the data line
    assign sda = sda_drv & (sda_oe ? sda_out : 1'b1);
    smbus_cfg_regs smbus_cfg_regs_inst (.CLK(clk), .RST(rst),
        .SCL_IN(scl), .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe),
        .CURRENT_MULT_STRAP_PINS(strap), .SPREAD_CODE(spread),
        .SW_FREQ_CODE(freq), .PROC_HUB_USB_EN(en1), .PERIPH_CLK_EN(en2),
        .FREERUN_REF_EN(en3), .CURRENT_MULT_SW_OVERRIDE(ovr),
        .CURRENT_MULT_SEL(mult));
    smbus_host smbus_host_inst (.clk(clk), .sda(sda), .scl(scl),
        .sda_drv(sda_drv));
    // 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [7:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask
    // address, command, one data byte; ack bits come back, 0 = acked
    task automatic frame(input logic [7:0] adr, cmd, dat,
                         output logic [2:0] a);
        logic [7:0] r;
        smbus_host_inst.start();
        smbus_host_inst.byte_io(adr, r, a[2]);
        smbus_host_inst.byte_io(cmd, r, a[1]);
        smbus_host_inst.byte_io(dat, r, a[0]);
        smbus_host_inst.stop();
    endtask
    // indexed read through repeated start; host ends with nack
    task automatic rd(input logic [7:0] cmd, output logic [7:0] q);
        logic [7:0] r;
        logic [3:0] a;
        smbus_host_inst.start();
        smbus_host_inst.byte_io(clkgen_cfg_pkg::ADDR_WRITE, r, a[3]);
        smbus_host_inst.byte_io(cmd, r, a[2]);
        smbus_host_inst.start();
        smbus_host_inst.byte_io(clkgen_cfg_pkg::ADDR_READ, r, a[1]);
        smbus_host_inst.byte_io(8'hff, q, a[0]);
        smbus_host_inst.stop();
        check("read acks", {4'h0, a}, 8'h01);
    endtask
    // verdict, called by the tests and by the watchdog
    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // watchdog; the tests need roughly 55 us
    initial begin
        #200000;
        bad_count++;
        summarize();
    end
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        strap = 2'h2;
        bad_count = 0;
        checks_done = 0;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        // power-up values at the outputs, strap seen as multiplier
        check("byte0 out", {spread, freq}, 8'h00);
        check("byte1 out", en1, 8'hff);
        check("byte2 out", {1'b0, en2}, 8'h7f);
        check("byte3 out", en3, 8'heb);
        check("mult out", {5'h0, ovr, mult}, 8'h02);
        for (int i = 0; i < 5; i++) begin
            rd(8'h80 | i[7:0], d);
            check("default", d, rstv[i]);
        end
        // write patterns, reserved bits must keep their defaults
        foreach (pats[p]) begin
            for (int i = 0; i < 5; i++) begin
                e = (pats[p] & wmask[i]) | (rstv[i] & ~wmask[i]);
                frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h80 | i[7:0],
                      pats[p], ak);
                check("write acks", {5'h0, ak}, 8'h00);
                rd(8'h80 | i[7:0], d);
                check("readback", d, e);
            end
        end
        check("byte0 out", {spread, freq}, 8'ha5);
        check("byte1 out", en1, 8'ha5);
        check("byte2 out", {1'b0, en2}, 8'h25);
        check("byte3 out", en3, 8'ha1);
        check("mult out", {5'h0, ovr, mult}, 8'h05);
        foreach (codes[c]) begin
            frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h80, {codes[c], 5'h0}, ak);
            check("spread", {5'h0, spread}, {5'h0, codes[c]});
        end
        for (int m = 0; m < 4; m++) begin
            frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h84, {1'b1, m[1:0], 5'h0}, ak);
            check("sw mult", {6'h0, mult}, {6'h0, m[1:0]});
        end
        frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h84, 8'h60, ak);
        check("strap mult", {5'h0, ovr, mult}, 8'h02);
        // refusals: foreign address, block command; index past the map is acked but not stored
        frame(8'hd0, 8'h81, 8'h00, ak);
        check("foreign ack", {7'h0, ak[2]}, 8'h01);
        frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h01, 8'h00, ak);
        check("block acks", {5'h0, ak}, 8'h03);
        frame(clkgen_cfg_pkg::ADDR_WRITE, 8'h85, 8'h00, ak);
        check("far acks", {5'h0, ak}, 8'h00);
        check("byte1 kept", en1, 8'ha5);
        rd(8'h85, d);
        check("far read", d, 8'h00);
        // reset in mid-run brings bytes 0 and 1 back to power-up, strap back as multiplier
        rst = 1'b1;
        repeat (8) @(negedge clk);
        rst = 1'b0;
        repeat (20) @(negedge clk);
        check("reset byte1", en1, clkgen_cfg_pkg::RST_BYTE1);
        check("reset mult", {5'h0, ovr, mult}, 8'h02);
        rd(8'h80, d);
        check("reset byte0", d, clkgen_cfg_pkg::RST_BYTE0);
        summarize();
    end
endmodule
